// ==== logic/pmc_map.vh ====
// Register offsets, field positions, reset values and encodings of the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PMC_PLL_CONTROL_REGISTER_OFS    8'h00
`define PMC_MODE_REQ_OFS   8'h04
`define PMC_VOLT_CTL_OFS   8'h08
`define PMC_PERIPH_EN_OFS  8'h0C
`define PMC_STATUS_OFS     8'h10
`define PMC_WAKE_EN_OFS    8'h14

// ****************************************
// Field positions
// ****************************************
`define PMC_PLL_DIS_BIT    0
`define PMC_BYPASS_BIT     1
`define PMC_MULT_LSB       2
`define PMC_MULT_MSB       7
`define PMC_FREQ_LSB       0
`define PMC_FREQ_MSB       1
`define PMC_WAKE_PIN_BIT   0
`define PMC_WAKE_RTC_BIT   1

// ****************************************
// Reset values
// ****************************************
`define PMC_MULT_RST       6'h0A
`define PMC_FREQ_RST       2'h3
`define PMC_PERIPH_RST     16'hFFFF
`define PMC_WAKE_EN_RST    2'h3

// ****************************************
// Mode encodings
// ****************************************
`define PMC_MODE_FULL_ON   3'h0
`define PMC_MODE_ACTIVE    3'h1
`define PMC_MODE_SLEEP     3'h2
`define PMC_MODE_DEEP      3'h3
`define PMC_MODE_HIBERNATE 3'h4

// ****************************************
// Bus responses
// ****************************************
`define PMC_RESP_OKAY      2'h0
`define PMC_RESP_SLVERR    2'h2

`endif

// ==== logic/pmc_controller.v ====
// Dynamic power mode controller with AXI4-Lite register slave
// Function
// - In full-on the PLL is enabled and not bypassed, core and system clocks run from the PLL.
// - After reset the controller sits in full-on.
// - In active the PLL is bypassed so both clocks run at the input clock pin rate.
// - A multiplier written in active is held and applied only on the next entry to full-on.
// - In active, DMA to level-one memory stays permitted.
// - In sleep the core clock is gated off while PLL and system clock keep running.
// - A wakeup from sleep picks full-on when bypass is clear and active when it is set.
// - In sleep all system DMA to level-one memory is blocked.
// - A zero-volt supply setting enters hibernate with PLL, clocks and core power off.
// - Each peripheral has its own clock gate under software control.
// - Exactly four operating modes plus the hibernate state exist.
// - In deep sleep PLL, core and system clocks stop while core power stays on.
// - Deep sleep exits only by reset to full-on or by an RTC interrupt to active.
// - Any enabled wakeup in hibernate starts the full hardware reset sequence.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pmc_map.vh"

module pmc_controller (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // Core and wake sources
    input  wire        core_idle_in,
    input  wire        wake_pin_in,
    input  wire        rtc_wake_in,
    // Clock tree and regulator controls
    output reg         pll_enable_out,
    output reg         pll_bypass_out,
    output reg  [5:0]  pll_mult_out,
    output reg         core_clock_en_out,
    output reg         sys_clock_en_out,
    output reg         core_power_out,
    output reg         dma_l1_allow_out,
    output reg  [15:0] periph_clock_en_out,
    output reg         hw_reset_req_out
);

// ****************************************
// Input synchronisers
// ****************************************
reg  [1:0] wake_pin_sync;
reg  [1:0] rtc_sync;
reg  [1:0] idle_sync;
wire       wake_pin;
wire       rtc_wake;
wire       core_idle;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        wake_pin_sync <= 2'h0;
        rtc_sync      <= 2'h0;
        idle_sync     <= 2'h0;
    end else begin
        wake_pin_sync <= {wake_pin_sync[0], wake_pin_in};
        rtc_sync      <= {rtc_sync[0], rtc_wake_in};
        idle_sync     <= {idle_sync[0], core_idle_in};
    end
end

assign wake_pin  = wake_pin_sync[1];
assign rtc_wake  = rtc_sync[1];
assign core_idle = idle_sync[1];

// ****************************************
// Registers
// ****************************************
reg        pll_dis;
reg        bypass;
reg  [5:0] mult_pending;
reg  [2:0] mode;
reg  [2:0] mode_req;
reg        req_pending;
reg  [1:0] freq;
reg [15:0] periph_en;
reg  [1:0] wake_en;

// Set states: full-on, active, sleep, deep sleep only; hibernate and higher codes map to full-on
function [2:0] pmc_legal;
    input [2:0] m;
    begin
        pmc_legal = (m > `PMC_MODE_DEEP) ? `PMC_MODE_FULL_ON : m;
    end
endfunction

// ****************************************
// AXI4-Lite write channel
// ****************************************
reg        aw_held;
reg  [7:0] aw_addr;
reg        w_held;
reg [31:0] w_data;
reg  [3:0] w_strb;
wire       wr_go;

assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
assign wr_go             = aw_held && w_held;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        aw_held          <= 1'b0;
        aw_addr          <= 8'h00;
        w_held           <= 1'b0;
        w_data           <= 32'h0000_0000;
        w_strb           <= 4'h0;
        s_axi_bvalid_out <= 1'b0;
        s_axi_bresp_out  <= `PMC_RESP_OKAY;
    end else begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end
        if (wr_go) begin
            aw_held          <= 1'b0;
            w_held           <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            case (aw_addr)
                `PMC_PLL_CONTROL_REGISTER_OFS, `PMC_MODE_REQ_OFS, `PMC_VOLT_CTL_OFS,
                `PMC_PERIPH_EN_OFS, `PMC_STATUS_OFS, `PMC_WAKE_EN_OFS: begin
                    s_axi_bresp_out <= `PMC_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp_out <= `PMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end
end

// ****************************************
// Mode sequencer and software registers
// ****************************************
reg  [2:0] next_mode;
reg        wake_any;

always @* begin
    next_mode = mode;
    wake_any  = (wake_pin && wake_en[`PMC_WAKE_PIN_BIT]) || (rtc_wake && wake_en[`PMC_WAKE_RTC_BIT]);
    case (mode)
        `PMC_MODE_FULL_ON, `PMC_MODE_ACTIVE: begin
            if (freq == 2'h0 && core_idle) begin
                next_mode = `PMC_MODE_HIBERNATE;
            end else if (req_pending && core_idle) begin
                next_mode = mode_req;
            end
        end
        `PMC_MODE_SLEEP: begin
            if (wake_any) begin
                next_mode = bypass ? `PMC_MODE_ACTIVE : `PMC_MODE_FULL_ON;
            end
        end
        `PMC_MODE_DEEP: begin
            if (rtc_wake) begin
                next_mode = `PMC_MODE_ACTIVE;
            end
        end
        `PMC_MODE_HIBERNATE: begin
            next_mode = `PMC_MODE_HIBERNATE;
        end
        default: begin
            next_mode = `PMC_MODE_FULL_ON;
        end
    endcase
end

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        mode             <= `PMC_MODE_FULL_ON;
        mode_req         <= `PMC_MODE_FULL_ON;
        req_pending      <= 1'b0;
        pll_dis          <= 1'b0;
        bypass           <= 1'b0;
        mult_pending     <= `PMC_MULT_RST;
        pll_mult_out     <= `PMC_MULT_RST;
        freq             <= `PMC_FREQ_RST;
        periph_en        <= `PMC_PERIPH_RST;
        wake_en          <= `PMC_WAKE_EN_RST;
        hw_reset_req_out <= 1'b0;
    end else begin
        mode <= next_mode;
        if (next_mode != mode) begin
            req_pending <= 1'b0;
        end
        // New multiplier reaches the PLL on entry to full-on, or at once when written in full-on
        if (next_mode == `PMC_MODE_FULL_ON && mode != `PMC_MODE_FULL_ON) begin
            pll_mult_out <= mult_pending;
        end
        // Reset sequence restores the supply setting so the state is left
        hw_reset_req_out <= (mode == `PMC_MODE_HIBERNATE) && wake_any;
        if (wr_go && w_strb[0]) begin
            case (aw_addr)
                `PMC_PLL_CONTROL_REGISTER_OFS: begin
                    // Disable only honoured in active; software re-enables before leaving
                    pll_dis      <= w_data[`PMC_PLL_DIS_BIT] && (mode == `PMC_MODE_ACTIVE);
                    bypass       <= w_data[`PMC_BYPASS_BIT];
                    mult_pending <= w_data[`PMC_MULT_MSB:`PMC_MULT_LSB];
                    if (mode == `PMC_MODE_FULL_ON) begin
                        pll_mult_out <= w_data[`PMC_MULT_MSB:`PMC_MULT_LSB];
                    end
                end
                `PMC_MODE_REQ_OFS: begin
                    mode_req    <= pmc_legal(w_data[2:0]);
                    req_pending <= 1'b1;
                end
                `PMC_VOLT_CTL_OFS: begin
                    freq <= w_data[`PMC_FREQ_MSB:`PMC_FREQ_LSB];
                end
                `PMC_WAKE_EN_OFS: begin
                    wake_en <= w_data[1:0];
                end
                default: begin
                    periph_en <= periph_en;
                end
            endcase
        end
        if (wr_go && aw_addr == `PMC_PERIPH_EN_OFS) begin
            if (w_strb[0]) periph_en[7:0]  <= w_data[7:0];
            if (w_strb[1]) periph_en[15:8] <= w_data[15:8];
        end
    end
end

// ****************************************
// Clock and power outputs per mode
// ****************************************
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        pll_enable_out      <= 1'b1;
        pll_bypass_out      <= 1'b0;
        core_clock_en_out   <= 1'b1;
        sys_clock_en_out    <= 1'b1;
        core_power_out      <= 1'b1;
        dma_l1_allow_out    <= 1'b1;
        periph_clock_en_out <= `PMC_PERIPH_RST;
    end else begin
        periph_clock_en_out <= periph_en & {16{next_mode < `PMC_MODE_DEEP}};
        case (next_mode)
            `PMC_MODE_FULL_ON: begin
                pll_enable_out    <= 1'b1;
                pll_bypass_out    <= 1'b0;
                core_clock_en_out <= 1'b1;
                sys_clock_en_out  <= 1'b1;
                core_power_out    <= 1'b1;
                dma_l1_allow_out  <= 1'b1;
            end
            `PMC_MODE_ACTIVE: begin
                pll_enable_out    <= !pll_dis;
                pll_bypass_out    <= 1'b1;
                core_clock_en_out <= 1'b1;
                sys_clock_en_out  <= 1'b1;
                core_power_out    <= 1'b1;
                dma_l1_allow_out  <= 1'b1;
            end
            `PMC_MODE_SLEEP: begin
                pll_enable_out    <= 1'b1;
                pll_bypass_out    <= bypass;
                core_clock_en_out <= 1'b0;
                sys_clock_en_out  <= 1'b1;
                core_power_out    <= 1'b1;
                dma_l1_allow_out  <= 1'b0;
            end
            `PMC_MODE_DEEP: begin
                pll_enable_out    <= 1'b0;
                pll_bypass_out    <= bypass;
                core_clock_en_out <= 1'b0;
                sys_clock_en_out  <= 1'b0;
                core_power_out    <= 1'b1;
                dma_l1_allow_out  <= 1'b0;
            end
            default: begin
                pll_enable_out    <= 1'b0;
                pll_bypass_out    <= 1'b0;
                core_clock_en_out <= 1'b0;
                sys_clock_en_out  <= 1'b0;
                core_power_out    <= 1'b0;
                dma_l1_allow_out  <= 1'b0;
            end
        endcase
    end
end

// ****************************************
// AXI4-Lite read channel
// ****************************************
assign s_axi_arready_out = !s_axi_rvalid_out;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_rdata_out  <= 32'h0000_0000;
        s_axi_rresp_out  <= `PMC_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out  <= `PMC_RESP_OKAY;
        case (s_axi_araddr_in)
            `PMC_PLL_CONTROL_REGISTER_OFS:   s_axi_rdata_out <= {24'h000000, mult_pending, bypass, pll_dis};
            `PMC_MODE_REQ_OFS:  s_axi_rdata_out <= {28'h0000000, req_pending, mode_req};
            `PMC_VOLT_CTL_OFS:  s_axi_rdata_out <= {30'h00000000, freq};
            `PMC_PERIPH_EN_OFS: s_axi_rdata_out <= {16'h0000, periph_en};
            `PMC_STATUS_OFS:    s_axi_rdata_out <= {18'h00000, pll_mult_out, core_idle, req_pending, 3'h0, mode};
            `PMC_WAKE_EN_OFS:   s_axi_rdata_out <= {30'h00000000, wake_en};
            default: begin
                s_axi_rdata_out <= 32'h0000_0000;
                s_axi_rresp_out <= `PMC_RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
    end
end

endmodule // pmc_controller

// ==== tb/pmc_controller_sva.sv ====
// Concurrent assertions on the power mode controller clock and power controls
`timescale 1ns/1ps
module pmc_controller_sva (
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire        pll_enable_out,
    input wire        pll_bypass_out,
    input wire        core_clock_en_out,
    input wire        sys_clock_en_out,
    input wire        core_power_out,
    input wire        dma_l1_allow_out,
    input wire [15:0] periph_clock_en_out,
    input wire        hw_reset_req_out
);
    // ****************************************
    // Mode decode from the clock controls
    // ****************************************
    wire sleep_st = core_power_out && sys_clock_en_out && !core_clock_en_out;
    wire deep_st  = core_power_out && !sys_clock_en_out;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_reset_left;
        $fell(rst_in);
    endsequence
    sequence s_deep_left;
        deep_st ##1 sys_clock_en_out;
    endsequence
    a_reset_full_on: assert property (s_reset_left |-> pll_enable_out && !pll_bypass_out && core_power_out)
        else $error("not in full-on after reset");
    a_full_on_pll: assert property (!pll_bypass_out && core_clock_en_out |-> pll_enable_out && sys_clock_en_out)
        else $error("full-on without running pll");
    a_active_clocks: assert property (pll_bypass_out && core_clock_en_out |-> sys_clock_en_out && dma_l1_allow_out)
        else $error("active mode clocks or dma wrong");
    a_sleep_gating: assert property (sleep_st |-> pll_enable_out && !dma_l1_allow_out)
        else $error("sleep mode pll or dma wrong");
    a_deep_stop: assert property (deep_st |-> !pll_enable_out && !core_clock_en_out && periph_clock_en_out == 16'h0000)
        else $error("deep sleep left something running");
    a_deep_exit: assert property (s_deep_left |-> pll_bypass_out && dma_l1_allow_out)
        else $error("deep sleep left to a mode other than active");
    a_hib_off: assert property (!core_power_out |-> !pll_enable_out && !sys_clock_en_out && !core_clock_en_out)
        else $error("hibernate with clocks running");
    a_hib_hold: assert property (!core_power_out |=> !core_power_out)
        else $error("hibernate resumed without reset");
    a_wake_reset: assert property (hw_reset_req_out |-> !core_power_out)
        else $error("reset request outside hibernate");
endmodule // pmc_controller_sva

bind pmc_controller pmc_controller_sva u_sva (
    .ref_clk_in, .rst_in, .pll_enable_out, .pll_bypass_out, .core_clock_en_out, .sys_clock_en_out,
    .core_power_out, .dma_l1_allow_out, .periph_clock_en_out, .hw_reset_req_out
);

// ==== tb/pmc_core_model.sv ====
// Behavioural core model that reports its idle point to the controller
`timescale 1ns/1ps
module pmc_core_model #(
    parameter DELAY = 3
) (
    input  wire ref_clk_in,
    input  wire rst_in,
    input  wire halt_in,
    input  wire core_clock_en_in,
    output reg  core_idle_out
);
    reg [3:0] wait_cnt;
    // Pipeline drains before idle; a gated core cannot leave idle
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in || (!halt_in && core_clock_en_in)) begin
            wait_cnt      <= 4'h0;
            core_idle_out <= 1'b0;
        end else if (wait_cnt == DELAY) begin
            core_idle_out <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // pmc_core_model

// ==== tb/pmc_controller_bench.sv ====
// Self-checking testbench for the power mode controller
`timescale 1ns/1ps
`include "pmc_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module pmc_controller_bench;
    // State vector {pll, bypass, core, sys, power, dma}
    localparam [5:0] FULL = 6'h2F, ACT = 6'h3F, SLP = 6'h26;
    reg         clk = 1'b0, rst = 1'b1, halt = 1'b0, wake_pin = 1'b0, rtc_wake = 1'b0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0, rdata_q;
    wire        awready, wready, bvalid, arready, rvalid, core_idle, hw_req;
    wire        pll_en, pll_byp, core_en, sys_en, power, dma;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [5:0]  mult;
    wire [15:0] periph;
    wire [5:0]  st = {pll_en, pll_byp, core_en, sys_en, power, dma};
    integer     num_errors = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    pmc_controller dut (
        .ref_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .core_idle_in(core_idle), .wake_pin_in(wake_pin), .rtc_wake_in(rtc_wake), .pll_enable_out(pll_en),
        .pll_bypass_out(pll_byp), .pll_mult_out(mult), .core_clock_en_out(core_en), .sys_clock_en_out(sys_en),
        .core_power_out(power), .dma_l1_allow_out(dma), .periph_clock_en_out(periph), .hw_reset_req_out(hw_req));
    pmc_core_model core (.ref_clk_in(clk), .rst_in(rst), .halt_in(halt), .core_clock_en_in(core_en),
        .core_idle_out(core_idle));
    // ****************************************
    // Bus and wait helpers
    // ****************************************
    task summarize; begin
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    task expire; begin
        num_errors++;
        $display("wrong value at %0t: wait expired", $time);
        summarize;
    end endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        integer i;
        begin
            awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            for (i = 0; i < 50; i++) begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) break;
            end
            if (i == 50) expire;
            bready <= 1'b0;
            `CHK(bresp, r)
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, input [1:0] r);
        integer i;
        begin
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            for (i = 0; i < 50; i++) begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) break;
            end
            if (i == 50) expire;
            rready <= 1'b0;
            rdata_q = rdata;
            `CHK(rresp, r)
            @(posedge clk);
        end
    endtask
    // Waits for the mode outputs to settle, then compares them under a mask
    task expect_st(input [5:0] e, input [5:0] m);
        integer i;
        begin
            for (i = 0; i < 40 && (st & m) !== e; i++) @(posedge clk);
            if (i == 40) expire;
            `CHK(st & m, e)
        end
    endtask
    task go_mode(input [2:0] m); begin
        wr(`PMC_MODE_REQ_OFS, {29'h0, m}, `PMC_RESP_OKAY);
        halt <= 1'b1;
    end endtask
    task do_reset; begin
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    end endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_active; begin
        wr(`PMC_MODE_REQ_OFS, 32'h1, `PMC_RESP_OKAY);
        repeat (8) @(posedge clk);
        `CHK(st, FULL)
        halt <= 1'b1;
        expect_st(ACT, 6'h3F);
        halt <= 1'b0;
        wr(`PMC_PLL_CONTROL_REGISTER_OFS, {24'h0, 6'h15, 2'h3}, `PMC_RESP_OKAY);
        expect_st(6'h1F, 6'h3F);
        `CHK(mult, 6'h0A)
        wr(`PMC_PLL_CONTROL_REGISTER_OFS, {24'h0, 6'h15, 2'h0}, `PMC_RESP_OKAY);
        go_mode(3'h0);
        expect_st(FULL, 6'h3F);
        `CHK(mult, 6'h15)
        halt <= 1'b0;
        $display("active test done");
    end endtask
    task t_sleep;
        integer b;
        begin
            for (b = 0; b < 2; b++) begin
                wr(`PMC_PLL_CONTROL_REGISTER_OFS, {24'h0, 6'h15, b[0], 1'b0}, `PMC_RESP_OKAY);
                go_mode(3'h2);
                expect_st(SLP, 6'h2F);
                halt <= 1'b0; wake_pin <= 1'b1;
                expect_st(b ? ACT : FULL, 6'h3F);
                wake_pin <= 1'b0;
            end
            wr(`PMC_PLL_CONTROL_REGISTER_OFS, {24'h0, 6'h15, 2'h0}, `PMC_RESP_OKAY);
            go_mode(3'h0);
            expect_st(FULL, 6'h3F);
            halt <= 1'b0;
            $display("sleep test done");
        end
    endtask
    task t_deep; begin
        go_mode(3'h3);
        expect_st(6'h02, 6'h2E);
        `CHK(periph, 16'h0000)
        halt <= 1'b0; wake_pin <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(st & 6'h2E, 6'h02)
        wake_pin <= 1'b0; rtc_wake <= 1'b1;
        expect_st(6'h1F, 6'h1F);
        rtc_wake <= 1'b0;
        `CHK(periph, 16'hFFFF)
        go_mode(3'h0);
        expect_st(FULL, 6'h3F);
        halt <= 1'b0;
        $display("deep sleep test done");
    end endtask
    task t_regs; begin
        wr(`PMC_PERIPH_EN_OFS, 32'h0000A5C3, `PMC_RESP_OKAY);
        `CHK(periph, 16'hA5C3)
        rd(`PMC_PERIPH_EN_OFS, `PMC_RESP_OKAY);
        `CHK(rdata_q[15:0], 16'hA5C3)
        rd(8'h1C, `PMC_RESP_SLVERR);
        wr(8'h18, 32'h0, `PMC_RESP_SLVERR);
        rd(`PMC_STATUS_OFS, `PMC_RESP_OKAY);
        `CHK(rdata_q, 32'h0000_1500)
        // Out-of-range request falls back to full-on
        wr(`PMC_MODE_REQ_OFS, 32'h7, `PMC_RESP_OKAY);
        rd(`PMC_MODE_REQ_OFS, `PMC_RESP_OKAY);
        `CHK(rdata_q, 32'h0000_0008)
        `CHK(st, FULL)
        $display("register test done");
    end endtask
    task t_hib;
        integer i;
        begin
            // Pin wake masked off, only the RTC may wake
            wr(`PMC_WAKE_EN_OFS, 32'h2, `PMC_RESP_OKAY);
            wr(`PMC_VOLT_CTL_OFS, 32'h0, `PMC_RESP_OKAY);
            halt <= 1'b1;
            expect_st(6'h00, 6'h2E);
            wake_pin <= 1'b1;
            repeat (8) @(posedge clk);
            `CHK(hw_req, 1'b0)
            rtc_wake <= 1'b1;
            for (i = 0; i < 20 && hw_req !== 1'b1; i++) @(posedge clk);
            `CHK(hw_req, 1'b1)
            wake_pin <= 1'b0; rtc_wake <= 1'b0; halt <= 1'b0;
            do_reset;
            `CHK(st, FULL)
            $display("hibernate test done");
        end
    endtask
    initial begin
        do_reset;
        `CHK(st, FULL)
        `CHK(periph, 16'hFFFF)
        t_active;
        t_sleep;
        t_deep;
        t_regs;
        t_hib;
        summarize;
    end
endmodule // pmc_controller_bench
